// ---- hdl/tpwm_chan.v ----
// One timer channel: capture, compare, edge and center PWM
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defs.vh"
module tpwm_chan (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        tick,
  input  wire        clk_on,
  input  wire        cpwm,
  input  wire [1:0]  mode,
  input  wire [1:0]  els,
  input  wire [15:0] cnt,
  input  wire [15:0] modv,
  input  wire        load_pt,
  input  wire        per_start,
  input  wire [15:0] wr_val,
  input  wire        wr_hi,
  input  wire        wr_lo,
  input  wire        pin_s,
  input  wire        ext_clk,
  output reg         pin_o,
  output reg         pin_oe_n,
  output reg  [15:0] val_q,
  output reg         flag_q
);
  reg [15:0] buf_q;
  reg        hi_q;
  reg        lo_q;
  reg        pin_d_q;
  reg        prev_s_q;
  reg        en_q;
  wire       own;
  wire       cap_m;
  wire       cmp_m;
  wire       edge_aligned_pwm_output_m;
  wire       match;
  wire       redge;
  wire       fedge;
  wire       both;
  assign own    = (els != `TPWM_ELS_OFF) && clk_on;
  assign cap_m  = !cpwm && (mode == `TPWM_MS_CAPT);
  assign cmp_m  = !cpwm && (mode == `TPWM_MS_CMP);
  assign edge_aligned_pwm_output_m = !cpwm && mode[1];
  assign match  = tick && (cnt == val_q);
  assign redge  = pin_s && !prev_s_q;
  assign fedge  = !pin_s && prev_s_q;
  assign both   = hi_q && lo_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      buf_q    <= 16'h0000;
      val_q    <= 16'h0000;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
      pin_d_q  <= 1'b0;
      prev_s_q <= 1'b0;
      flag_q   <= 1'b0;
      en_q     <= 1'b0;
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      prev_s_q <= pin_s;
      // With a clock selected, center mode loads buffered value only at the modulo-minus-one step while counting up
      if (cpwm && clk_on) begin
        if (both && tick && load_pt) begin
          val_q <= buf_q;
          hi_q  <= 1'b0;
          lo_q  <= 1'b0;
        end
      end else if (both) begin
        val_q <= buf_q;
        hi_q  <= 1'b0;
        lo_q  <= 1'b0;
      end
      // Writes after the load so a byte landing on it is not lost
      if (wr_hi) begin
        buf_q[15:8] <= wr_val[15:8];
        hi_q        <= 1'b1;
      end
      if (wr_lo) begin
        buf_q[7:0] <= wr_val[7:0];
        lo_q       <= 1'b1;
      end
      flag_q <= 1'b0;
      if (cap_m && own && !ext_clk) begin
        if ((els[0] && redge) || (els[1] && fedge)) begin
          val_q  <= cnt;
          flag_q <= 1'b1;
        end
      end else if (cmp_m && match && (own || ext_clk)) begin
        flag_q <= 1'b1;
        case (els)
          `TPWM_ELS_TOG: pin_d_q <= !pin_d_q;
          `TPWM_ELS_CLR: pin_d_q <= 1'b0;
          `TPWM_ELS_SET: pin_d_q <= 1'b1;
          default:       pin_d_q <= pin_d_q;
        endcase
      end else if (edge_aligned_pwm_output_m && own && tick) begin
        // Edge PWM: with els[0] clear, high from period start until match
        if (cnt == val_q)
          pin_d_q <= els[0];
        else if (per_start)
          pin_d_q <= !els[0];
      end else if (cpwm && own && tick) begin
        // Full duty at modulo; modulo minus one stays nearly full
        if (val_q == modv && modv != 16'h0000)
          pin_d_q <= !els[0];
        else if (val_q == 16'h0000)
          pin_d_q <= els[0];
        else if (cnt < val_q)
          pin_d_q <= !els[0];
        else
          pin_d_q <= els[0];
      end
      en_q <= own && !cap_m && !(ext_clk && !cpwm);
      // Frozen without clock; otherwise track pin for a clean takeover
      if (!own && clk_on)
        pin_d_q <= pin_s;
      pin_o    <= pin_d_q;
      pin_oe_n <= !en_q;
    end
  end
endmodule // tpwm_chan
`default_nettype wire

// ---- hdl/tpwm_defs.vh ----
// Constants for the timer and PWM channel block
// Behaviour
// - One to eight channels, each capture, compare or edge-aligned PWM.
// - Sixteen-bit counter behind a prescaler, bounded by the modulo.
// - Clock source selects none, bus, crystal or synchronised external clock.
// - With external clock, shared channel still compares as software timer.
// - Channel releases pin when edge/level select zero or no clock.
// - Center PWM select with nonzero edge/level makes all channels center PWM.
// - Without center PWM, mode select picks capture, compare or edge PWM.
// - Capture when mode zero; edge/level select picks capture edges.
// - Capture inputs synchronised; pulses must last four bus clocks.
// - Compare toggles, clears or sets pin when value equals counter.
// - Toggle mode keeps previous pin level until first match.
// - Center PWM values load after both bytes, at modulo minus one step.
// - Center PWM value equal to modulo gives full duty.
// - Center PWM value modulo minus one gives nearly full duty.
// - Change from zero to nonzero takes effect at next period.
// - Change from nonzero to zero finishes current period with old value.
// - Debug-mode status/control write resets modulo byte coherency.
// - Edge PWM output frozen while no clock is selected.
`ifndef TPWM_DEFS_VH
`define TPWM_DEFS_VH
`define TPWM_CLK_NONE  2'h0
`define TPWM_CLK_BUS   2'h1
`define TPWM_CLK_XTAL  2'h2
`define TPWM_CLK_EXT   2'h3
`define TPWM_MS_CAPT   2'h0
`define TPWM_MS_CMP    2'h1
`define TPWM_ELS_OFF   2'h0
`define TPWM_ELS_TOG   2'h1
`define TPWM_ELS_CLR   2'h2
`define TPWM_ELS_SET   2'h3
`define TPWM_CNT_RST   16'h0000
`define TPWM_MOD_RST   16'h0000
`define TPWM_CNT_FULL  16'hffff
`define TPWM_CNT_PEN   16'hfffe
`define TPWM_PRE_W     3
`endif

// ---- hdl/tpwm_sync.v ----
// Two-flop synchroniser for pin-side levels
`timescale 1ns/1ps
`default_nettype none
module tpwm_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // tpwm_sync
`default_nettype wire

// ---- hdl/tpwm_top.v ----
// Timer counter with prescaler, modulo and N channels
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defs.vh"
module tpwm_top #(
  parameter NCH = 8
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire [1:0]          clock_source_select,
  input  wire [2:0]          prescale_sel,
  input  wire                center_pwm_select,
  input  wire                xtal_tick,
  input  wire                external_timer_clock,
  input  wire                background_debug_mode,
  input  wire                timer_status_control_wr,
  input  wire [15:0]         mod_wdata,
  input  wire                mod_wr_hi,
  input  wire                mod_wr_lo,
  input  wire [2*NCH-1:0]    channel_mode_select,
  input  wire [2*NCH-1:0]    edge_level_select,
  input  wire [16*NCH-1:0]   channel_value_wdata,
  input  wire [NCH-1:0]      chan_wr_hi,
  input  wire [NCH-1:0]      chan_wr_lo,
  input  wire [NCH-1:0]      timer_channel_pin_i,
  output wire [NCH-1:0]      timer_channel_pin_o,
  output wire [NCH-1:0]      timer_channel_pin_oe_n,
  output wire [16*NCH-1:0]   channel_value,
  output wire [NCH-1:0]      chan_event,
  output reg  [15:0]         counter_q,
  output reg  [15:0]         counter_modulo,
  output reg                 overflow_q
);
  reg  [`TPWM_PRE_W+4:0] pre_q;
  reg  [15:0]            mod_buf_q;
  reg                    mhi_q;
  reg                    mlo_q;
  reg                    ext_prev_q;
  reg                    up_q;
  reg                    src_tick;
  reg                    tick;
  wire                   ext_s;
  wire [NCH-1:0]         pin_s;
  wire                   clk_on;
  wire [15:0]            top;
  wire                   load_pt;
  wire                   per_start;
  integer                k;
  function [15:0] topv;
    input [15:0] m;
    begin
      topv = (m == 16'h0000) ? `TPWM_CNT_FULL : m;
    end
  endfunction
  assign clk_on = clock_source_select != `TPWM_CLK_NONE;
  assign top    = topv(counter_modulo);
  assign load_pt = counter_q == top - 16'h0001;
  assign per_start = counter_q == 16'h0000;
  tpwm_sync #(.W(1)) u_ext (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (external_timer_clock),
    .sync_out (ext_s)
  );
  tpwm_sync #(.W(NCH)) u_pins (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (timer_channel_pin_i),
    .sync_out (pin_s)
  );
  always @* begin
    case (clock_source_select)
      `TPWM_CLK_BUS:  src_tick = 1'b1;
      `TPWM_CLK_XTAL: src_tick = xtal_tick;
      `TPWM_CLK_EXT:  src_tick = ext_s && !ext_prev_q;
      default:        src_tick = 1'b0;
    endcase
    tick = 1'b0;
    for (k = 0; k < 8; k = k + 1)
      if (k[2:0] == prescale_sel && src_tick)
        tick = (pre_q & ((8'h01 << k) - 8'h01)) == 8'h00;
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      pre_q          <= 8'h00;
      counter_q      <= `TPWM_CNT_RST;
      counter_modulo <= `TPWM_MOD_RST;
      mod_buf_q      <= 16'h0000;
      mhi_q          <= 1'b0;
      mlo_q          <= 1'b0;
      ext_prev_q     <= 1'b0;
      up_q           <= 1'b1;
      overflow_q     <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
      overflow_q <= 1'b0;
      if (src_tick)
        pre_q <= pre_q + 8'h01;
      if (background_debug_mode && timer_status_control_wr) begin
        mhi_q <= 1'b0;
        mlo_q <= 1'b0;
      end else if (mhi_q && mlo_q) begin
        counter_modulo <= mod_buf_q;
        mhi_q          <= 1'b0;
        mlo_q          <= 1'b0;
      end
      // Writes after the load so a byte landing on it is not lost
      if (mod_wr_hi) begin
        mod_buf_q[15:8] <= mod_wdata[15:8];
        mhi_q           <= 1'b1;
      end
      if (mod_wr_lo) begin
        mod_buf_q[7:0] <= mod_wdata[7:0];
        mlo_q          <= 1'b1;
      end
      if (tick) begin
        if (center_pwm_select) begin
          // Up-down count for center alignment
          if (up_q && counter_q >= top) begin
            up_q      <= 1'b0;
            counter_q <= counter_q - 16'h0001;
          end else if (!up_q && counter_q == 16'h0000) begin
            up_q       <= 1'b1;
            counter_q  <= 16'h0001;
            overflow_q <= 1'b1;
          end else
            counter_q <= up_q ? counter_q + 16'h0001 : counter_q - 16'h0001;
        end else if (counter_q >= top) begin
          counter_q  <= 16'h0000;
          overflow_q <= 1'b1;
          up_q       <= 1'b1;
        end else
          counter_q <= counter_q + 16'h0001;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      tpwm_chan u_ch (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .tick      (tick),
        .clk_on    (clk_on),
        .cpwm      (center_pwm_select),
        .mode      (channel_mode_select[2*g+1:2*g]),
        .els       (edge_level_select[2*g+1:2*g]),
        .cnt       (counter_q),
        .modv      (top),
        .load_pt   (load_pt && up_q),
        .per_start (per_start),
        .wr_val    (channel_value_wdata[16*g+15:16*g]),
        .wr_hi     (chan_wr_hi[g]),
        .wr_lo     (chan_wr_lo[g]),
        .pin_s     (pin_s[g]),
        .ext_clk   ((g == 0) && (clock_source_select == `TPWM_CLK_EXT)),
        .pin_o     (timer_channel_pin_o[g]),
        .pin_oe_n  (timer_channel_pin_oe_n[g]),
        .val_q     (channel_value[16*g+15:16*g]),
        .flag_q    (chan_event[g])
      );
    end
  endgenerate
endmodule // tpwm_top
`default_nettype wire

// ---- verification/tpwm_chk.sv ----
// Assertion checker bound to the timer block top
`timescale 1ns/1ps
`default_nettype none
module tpwm_chk #(
  parameter NCH = 2
) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [1:0]       clock_source_select,
  input wire logic             center_pwm_select,
  input wire logic [2*NCH-1:0] channel_mode_select,
  input wire logic [2*NCH-1:0] edge_level_select,
  input wire logic [NCH-1:0]   timer_channel_pin_o,
  input wire logic [NCH-1:0]   timer_channel_pin_oe_n,
  input wire logic [15:0]      counter_q,
  input wire logic [15:0]      counter_modulo
);
  // Three cycles of settle cover the two-cycle pin pipeline
  wire           off  = (clock_source_select == 2'h0);
  wire           up   = !center_pwm_select;
  wire [1:0]     els0 = edge_level_select[1:0];
  wire [1:0]     els1 = edge_level_select[3:2];
  wire [1:0]     ms0  = channel_mode_select[1:0];
  wire [1:0]     ms1  = channel_mode_select[3:2];
  wire [NCH-1:0] oe_n = timer_channel_pin_oe_n;
  wire [15:0]    cq   = counter_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rel_els; (els0 == 2'h0) [*3] |-> oe_n[0]; endproperty
  a_rel_els: assert property (p_rel_els) else $error("pin 0 not released");
  property p_rel_clk; off [*3] |-> &oe_n; endproperty
  a_rel_clk: assert property (p_rel_clk) else $error("pin driven without clock");
  property p_cap_in; (up && ms0 == 2'h0 && els0 != 2'h0) [*3] |-> oe_n[0]; endproperty
  a_cap_in: assert property (p_cap_in) else $error("capture pin driven");
  property p_cmp_out; (!off && up && ms1 == 2'h1 && els1 != 2'h0) [*3] |-> !oe_n[1];
  endproperty
  a_cmp_out: assert property (p_cmp_out) else $error("compare pin not driven");
  property p_cpwm_out; (!off && !up && els1 != 2'h0) [*3] |-> !oe_n[1]; endproperty
  a_cpwm_out: assert property (p_cpwm_out) else $error("center pin not driven");
  property p_wrap; (up && $past(up) && $changed(cq) && $past(counter_modulo) != 16'h0000
    && $past(cq) == $past(counter_modulo)) |-> cq == 16'h0000; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at modulo");
  property p_free; (up && $past(up) && $changed(cq) && $past(cq) == 16'hffff)
    |-> cq == 16'h0000; endproperty
  a_free: assert property (p_free) else $error("no wrap at full count");
  property p_step; (up && $past(up) && $changed(cq))
    |-> (cq == $past(cq) + 16'h0001 || cq == 16'h0000); endproperty
  a_step: assert property (p_step) else $error("counter skipped");
  property p_hold; off [*3] |-> $stable(cq); endproperty
  a_hold: assert property (p_hold) else $error("counter moved without clock");
  property p_pin_frz; off [*5] |-> $stable(timer_channel_pin_o); endproperty
  a_pin_frz: assert property (p_pin_frz) else $error("pin moved without clock");
endmodule // tpwm_chk
bind tpwm_top tpwm_chk #(.NCH(NCH)) i_tpwm_chk (.clk, .sys_rst, .clock_source_select,
  .center_pwm_select, .channel_mode_select, .edge_level_select, .timer_channel_pin_o,
  .timer_channel_pin_oe_n, .counter_q, .counter_modulo);
`default_nettype wire

// ---- verification/tpwm_pin_model.sv ----
// Far side of the two channel pins: external clock and capture pulses
`timescale 1ns/1ps
`default_nettype none
module tpwm_pin_model (
  input  wire logic       clk,
  input  wire logic       ext_en,
  input  wire logic       pulse_req,
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe_n,
  output var  logic [1:0] pin_i
);
  logic [2:0] div_q = 3'h0;
  logic [2:0] pls_q = 3'h0;
  logic [1:0] far;
  always @(posedge clk) begin
    div_q  <= ext_en ? div_q + 3'h1 : 3'h0;
    pls_q  <= pulse_req ? 3'h6 : pls_q - {2'h0, pls_q != 3'h0};
  end
  always @* begin
    // Pull-up holds the second line high while released
    far   = {1'b1, div_q[2] | (pls_q != 3'h0)};
    pin_i = (pin_oe_n & far) | (~pin_oe_n & pin_o);
  end
endmodule // tpwm_pin_model
`default_nettype wire

// ---- verification/tpwm_top_tb.sv ----
// Self-checking bench for the timer block with its pin model
`timescale 1ns/1ps
`default_nettype none
module tpwm_top_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, cps = 1'b0, xtk = 1'b0, dbg = 1'b0;
  logic        scw = 1'b0, mhi = 1'b0, mlo = 1'b0, ext_en = 1'b0, preq = 1'b0;
  logic [1:0]  css = 2'h0, chi = 2'h0, clo = 2'h0;
  logic [2:0]  pre = 3'h0;
  logic [3:0]  ms = 4'h0, els = 4'h0;
  logic [15:0] mwd = 16'h0000, m, v, c0;
  logic [31:0] cwd = 32'h0000_0000;
  wire  [1:0]  pin_i, pin_o, oe_n, ev;
  wire  [31:0] cval;
  wire  [15:0] cnt, modv;
  wire         ovf;
  integer      fails = 0, total_checks = 0, seed = 32'hf52a, cyc = 0, n, k, hi, lvl;
  always #5 clk = ~clk;
  always @(negedge clk) xtk <= (css == 2'h2) && (cyc % 4 == 0);
  tpwm_top #(.NCH(2)) i_tpwm_top (.clk, .sys_rst, .clock_source_select(css),
    .prescale_sel(pre), .center_pwm_select(cps), .xtal_tick(xtk),
    .external_timer_clock(pin_i[0]), .background_debug_mode(dbg),
    .timer_status_control_wr(scw), .mod_wdata(mwd), .mod_wr_hi(mhi), .mod_wr_lo(mlo),
    .channel_mode_select(ms), .edge_level_select(els), .channel_value_wdata(cwd),
    .chan_wr_hi(chi), .chan_wr_lo(clo), .timer_channel_pin_i(pin_i),
    .timer_channel_pin_o(pin_o), .timer_channel_pin_oe_n(oe_n), .channel_value(cval),
    .chan_event(ev), .counter_q(cnt), .counter_modulo(modv), .overflow_q(ovf));
  tpwm_pin_model i_tpwm_pin_model (.clk, .ext_en, .pulse_req(preq), .pin_o,
    .pin_oe_n(oe_n), .pin_i);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cy(input integer c); repeat (c) @(negedge clk); endtask
  task automatic wmod(input logic [15:0] d);
    mwd = d; mhi = 1'b1; cy(1); mhi = 1'b0; mlo = 1'b1; cy(1); mlo = 1'b0;
  endtask
  task automatic wch(input integer c, input logic [15:0] d);
    cwd[16*c +: 16] = d; chi[c] = 1'b1; cy(1); chi[c] = 1'b0; clo[c] = 1'b1; cy(1);
    clo[c] = 1'b0;
  endtask
  // Sel 0/1 channel event, 2 overflow, 3 counter equal to c
  task automatic upto(input integer sel, input logic [15:0] c, input integer lim);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (n < lim && !hit) begin
      @(negedge clk);
      n = n + 1;
      hit = sel < 2 ? ev[sel] === 1'b1 : sel == 2 ? ovf === 1'b1 : cnt === c;
    end
    // A wait that runs out counts as a mismatch
    if (!hit) fails = fails + 1;
  endtask
  task automatic duty(input integer c);
    hi = 0;
    repeat (c) begin @(negedge clk); hi = hi + pin_o[1]; end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin fails = fails + 1; wrap_up; end
  end
  initial begin
    cy(6); sys_rst = 1'b0; cy(4);
    chk(cnt, 16'h0000); chk(modv, 16'h0000); chk(oe_n, 2'h3);
    css = 2'h1;
    // Modulo only grows so the counter never runs past it
    for (k = 0; k < 3; k = k + 1) begin
      m = 16'h0010 * (k + 1) + ($random(seed) & 16'h000f); pre = k[2:0];
      wmod(m); cy(3); chk(modv, m);
      upto(2, 0, 1000); upto(2, 0, 1000); chk(n, (m + 16'h0001) << k);
    end
    pre = 3'h0; ms = 4'h4; lvl = 1;
    for (k = 3; k > 0; k = k - 1) begin
      v = $unsigned($random(seed)) % m; wch(1, v); cy(2);
      chk(cval[31:16], v);
      els[3:2] = k[1:0];
      repeat (2) begin
        upto(1, 0, 200); chk(pin_o[1], lvl[0]);
        lvl = (k == 1) ? 1 - lvl : (k == 3); cy(3); chk(pin_o[1], lvl[0]);
      end
    end
    els[1:0] = 2'h3; cy(3); c0 = cnt; preq = 1'b1; cy(1); preq = 1'b0;
    upto(0, 0, 20); chk(n < 20, 1'b1); chk(oe_n[0], 1'b1);
    chk(cval[15:0], (c0 + 16'h0003) % (m + 16'h0001));
    cps = 1'b1; els[3:2] = 2'h2; wch(1, m); cy(6 * m);
    duty(2 * m); chk(hi, 2 * m);
    wch(1, m - 16'h0001); cy(6 * m); duty(2 * m);
    chk(hi < 2 * m && hi > 2 * m - 5, 1'b1);
    upto(3, 16'h0002, 4000); wch(1, 16'h0000); cy(2);
    chk(cval[31:16], m - 16'h0001);
    chk(pin_o[1], 1'b1);
    upto(3, m, 4000); cy(3); chk(cval[31:16], 16'h0000);
    upto(3, m >> 1, 4000); chk(pin_o[1], 1'b0);
    upto(3, 16'h0002, 4000); wch(1, m); cy(2);
    chk(pin_o[1], 1'b0);
    upto(3, m, 4000); upto(3, m >> 1, 4000); chk(pin_o[1], 1'b1);
    cps = 1'b0; dbg = 1'b1; mwd = 16'h0100;
    mhi = 1'b1; cy(1); mhi = 1'b0; scw = 1'b1; cy(1); scw = 1'b0;
    mlo = 1'b1; cy(1); mlo = 1'b0; cy(3); chk(modv, m);
    wmod(16'h0100); cy(3); chk(modv, 16'h0100); dbg = 1'b0;
    // Edge PWM: two whole periods of 257 counts, high for the value each
    ms = 4'h8; els[3:2] = 2'h2; wch(1, 16'h0040); cy(300); duty(514);
    chk(hi, 16'h0080);
    wmod(16'h0000); ms = 4'h9; els = 4'h8;
    // Crystal ticks every 4 cycles, external clock every 8
    for (k = 2; k < 4; k = k + 1) begin
      css = k[1:0]; ext_en = (k == 3); cy(20); c0 = cnt; cy(80); v = cnt - c0;
      chk(v + 16'h0001 >= 80 / (4 * k - 4) && v <= 80 / (4 * k - 4) + 1, 1'b1);
    end
    wch(0, cnt + 16'h0005); upto(0, 0, 100); chk(n < 100, 1'b1);
    chk(oe_n[0], 1'b1);
    css = 2'h0; ext_en = 1'b0; cy(6); v = {15'h0000, pin_o[1]};
    els[3:2] = 2'h3; cy(10); chk(pin_o[1], v[0]); chk(oe_n, 2'h3);
    css = 2'h1; upto(3, 16'hffff, 70000); upto(3, 16'h0000, 4);
    chk(n < 4, 1'b1);
    wrap_up;
  end
endmodule // tpwm_top_tb
`default_nettype wire
